// ### imu_results_top.sv
// Result registers, global trigger word and serial access of the inertial block
//
// Function
// - Separate result register per sensor axis
// - Rate words sixteen-bit twos complement
// - Acceleration words sixteen-bit twos complement
// - Temperature in low twelve bits only
// - Rate y and z at 0x06, 0x08
// - Accel y and z at 0x0c, 0x0e
// - Temperature readable at 0x18
// - Writing a one launches that task
// - Trigger bit clears itself when done
// - Bit seven starts software reset
// - Bit three starts flash backup
// - Reload controls before new result data
// - Trigger resets zero, unused bits ignored
// - Continuous sampling loads all results
// - Burst read returns eight words
// - One byte written per frame
`timescale 1ns/1ps
`include "imu_defs.svh"
module imu_results_top
    import imu_pkg::*;
#(
    parameter int SAMPLE_CYC = int'((64'(`IMU_CLK_HZ) * 64'(`IMU_DECI_SCALE)) / 64'(`IMU_SAMPLE_DSPS)),
    parameter int FLASH_CYC  = `IMU_FLASH_MS * (`IMU_CLK_HZ / `IMU_MS_PER_S),
    parameter int RESET_CYC  = `IMU_TASK_CYC,
    parameter int CALIB_CYC  = `IMU_TASK_CYC,
    parameter int BIAS_CYC   = `IMU_TASK_CYC,
    parameter int RELOAD_CYC = `IMU_RELOAD_CYC
)
(
    input  wire logic        clk_sys_i,
    input  wire logic        rst_b_i,
    input  wire logic        sclk_i,
    input  wire logic        cs_b_i,
    input  wire logic        mosi_i,
    input  wire logic [15:0] sens_rate_x_i,
    input  wire logic [15:0] sens_rate_y_i,
    input  wire logic [15:0] sens_rate_z_i,
    input  wire logic [15:0] sens_accel_x_i,
    input  wire logic [15:0] sens_accel_y_i,
    input  wire logic [15:0] sens_accel_z_i,
    input  wire logic [11:0] sens_temp_i,
    output logic             miso_o,
    output logic             data_ready_o,
    output logic [3:0]       task_busy_o,
    output logic             ctrl_reload_o
);
    // ****************************************************************
    // Crossing from the serial clock
    // ****************************************************************
    imu_word_t  rx_word, tx_word, next_tx;
    logic       rx_tgl, tgl_s, tgl_d, cs_b_s, frame_evt;
    logic [6:0] rx_addr;

    imu_spi_link u_link
    (
        .sclk_i    (sclk_i),
        .cs_b_i    (cs_b_i),
        .rst_b_i   (rst_b_i),
        .mosi_i    (mosi_i),
        .tx_word_i (tx_word),
        .miso_o    (miso_o),
        .rx_word_o (rx_word),
        .rx_tgl_o  (rx_tgl)
    );

    imu_sync2 u_sync
    (
        .clk_sys_i (clk_sys_i),
        .rst_b_i   (rst_b_i),
        .d_i       ({rx_tgl, cs_b_i}),
        .q_o       ({tgl_s, cs_b_s})
    );

    always_ff @(posedge clk_sys_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            tgl_d <= 1'b0;
        else
            tgl_d <= tgl_s;
    end

    // Word is stable: the link changes it only sixteen serial edges later
    assign frame_evt = tgl_s ^ tgl_d;
    assign rx_addr   = rx_word[`IMU_FRM_ADDR];

    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic logic [3:0] res_index(input logic [6:0] a);
        logic [6:0] w;
        w = {a[6:1], 1'b0};
        if (w == `IMU_ADDR_RATE_X)       res_index = 4'h0;
        else if (w == `IMU_ADDR_RATE_Y)  res_index = 4'h1;
        else if (w == `IMU_ADDR_RATE_Z)  res_index = 4'h2;
        else if (w == `IMU_ADDR_ACCEL_X) res_index = 4'h3;
        else if (w == `IMU_ADDR_ACCEL_Y) res_index = 4'h4;
        else if (w == `IMU_ADDR_ACCEL_Z) res_index = 4'h5;
        else if (w == `IMU_ADDR_TEMP)    res_index = 4'h6;
        else                             res_index = `IMU_IDX_NONE;
    endfunction

    function automatic logic [31:0] task_len(input logic [1:0] t);
        case (t)
            `IMU_TK_RESET: task_len = 32'(RESET_CYC - 1);
            `IMU_TK_FLASH: task_len = 32'(FLASH_CYC - 1);
            `IMU_TK_CALIB: task_len = 32'(CALIB_CYC - 1);
            default:       task_len = 32'(BIAS_CYC - 1);
        endcase
    endfunction

    function automatic logic needs_reload(input logic [1:0] t);
        needs_reload = (t == `IMU_TK_RESET) || (t == `IMU_TK_FLASH);
    endfunction

    // ****************************************************************
    // Global trigger word and task sequencer
    // ****************************************************************
    imu_task_e  state, next_state;
    logic [3:0] trig, next_trig, set_bits, next_busy;
    logic [1:0] cur, next_cur;
    logic [31:0] timer, next_timer;
    logic       hold, trig_wr;

    assign trig_wr = frame_evt && rx_word[`IMU_FRM_WR] && (rx_addr == `IMU_ADDR_TRIG);

    always_comb
    begin
        next_state = state;
        next_cur   = cur;
        next_timer = timer;
        set_bits   = 4'h0;
        if (trig_wr)
        begin
            set_bits[`IMU_TK_RESET] = rx_word[`IMU_TRIG_RESET];
            set_bits[`IMU_TK_FLASH] = rx_word[`IMU_TRIG_FLASH];
            set_bits[`IMU_TK_CALIB] = rx_word[`IMU_TRIG_CALIB];
            set_bits[`IMU_TK_BIAS]  = rx_word[`IMU_TRIG_BIAS];
        end
        next_trig = trig;
        case (state)
            TK_IDLE:
                if (trig != 4'h0)
                begin
                    // Calibration work runs before the flash copy, reset before all
                    if (trig[`IMU_TK_RESET])      next_cur = `IMU_TK_RESET;
                    else if (trig[`IMU_TK_BIAS])  next_cur = `IMU_TK_BIAS;
                    else if (trig[`IMU_TK_CALIB]) next_cur = `IMU_TK_CALIB;
                    else                          next_cur = `IMU_TK_FLASH;
                    next_timer = task_len(next_cur);
                    next_state = TK_RUN;
                end
            TK_RUN:
                if (timer == 32'h0)
                begin
                    next_trig[cur] = 1'b0;
                    if (needs_reload(cur))
                    begin
                        next_timer = 32'(RELOAD_CYC - 1);
                        next_state = TK_RELOAD;
                    end
                    else
                        next_state = TK_IDLE;
                end
                else
                    next_timer = timer - 32'h1;
            TK_RELOAD:
                if (timer == 32'h0)
                    next_state = TK_IDLE;
                else
                    next_timer = timer - 32'h1;
            default:
                next_state = TK_IDLE;
        endcase
        // A write in the clearing cycle still launches its task
        next_trig = next_trig | set_bits;
        next_busy = 4'h0;
        if (next_state == TK_RUN)
            next_busy[next_cur] = 1'b1;
    end

    always_ff @(posedge clk_sys_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            state         <= TK_IDLE;
            trig          <= 4'h0;
            cur           <= `IMU_TK_BIAS;
            timer         <= 32'h0;
            task_busy_o   <= 4'h0;
            ctrl_reload_o <= 1'b0;
        end
        else
        begin
            state         <= next_state;
            trig          <= next_trig;
            cur           <= next_cur;
            timer         <= next_timer;
            task_busy_o   <= next_busy;
            ctrl_reload_o <= (next_state == TK_RELOAD);
        end
    end

    // Fresh results wait until the control settings are back from flash
    assign hold = (state == TK_RELOAD) || ((state == TK_RUN) && needs_reload(cur));

    // ****************************************************************
    // Sample cycle and result registers
    // ****************************************************************
    imu_word_t   res [0:6];
    imu_word_t   next_res [0:6];
    logic [31:0] samp_cnt, next_samp;
    logic        tick, next_drdy;

    always_comb
    begin
        tick      = (samp_cnt == 32'(SAMPLE_CYC - 1));
        next_samp = tick ? 32'h0 : samp_cnt + 32'h1;
        next_drdy = tick && !hold;
        next_res  = res;
        if (tick && !hold)
        begin
            next_res[0] = sens_rate_x_i;
            next_res[1] = sens_rate_y_i;
            next_res[2] = sens_rate_z_i;
            next_res[3] = sens_accel_x_i;
            next_res[4] = sens_accel_y_i;
            next_res[5] = sens_accel_z_i;
            next_res[6] = {`IMU_TEMP_PAD, sens_temp_i};
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            samp_cnt     <= 32'h0;
            data_ready_o <= 1'b0;
            for (int i = 0; i < 7; i++)
                res[i] <= 16'h0000;
        end
        else
        begin
            samp_cnt     <= next_samp;
            data_ready_o <= next_drdy;
            res          <= next_res;
        end
    end

    // ****************************************************************
    // Reply word for the next frame
    // ****************************************************************
    logic       burst_on, next_bon;
    logic [2:0] burst_idx, next_bidx;
    logic [3:0] ridx;

    always_comb
    begin
        next_tx   = tx_word;
        next_bon  = burst_on && !cs_b_s;
        next_bidx = burst_idx;
        ridx      = res_index(rx_addr);
        if (frame_evt)
        begin
            if (burst_on && (burst_idx != `IMU_BURST_LAST))
            begin
                next_bidx = burst_idx + 3'h1;
                next_tx   = res[next_bidx - 3'h1];
            end
            else
            begin
                next_bon = 1'b0;
                next_tx  = 16'h0000;
                if (!rx_word[`IMU_FRM_WR] && (rx_addr == `IMU_ADDR_TRIG))
                begin
                    next_bon  = 1'b1;
                    next_bidx = 3'h0;
                    next_tx   = `IMU_DIAG_VAL;
                end
                else if (!rx_word[`IMU_FRM_WR] && (ridx != `IMU_IDX_NONE))
                    next_tx = res[ridx[2:0]];
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            tx_word   <= 16'h0000;
            burst_on  <= 1'b0;
            burst_idx <= 3'h0;
        end
        else
        begin
            tx_word   <= next_tx;
            burst_on  <= next_bon;
            burst_idx <= next_bidx;
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_b_i);

    sequence s_trig_wr(int b);
        trig_wr && rx_word[b];
    endsequence
    sequence s_rd(logic [6:0] a);
        frame_evt && !rx_word[`IMU_FRM_WR] && !burst_on && (rx_addr == a);
    endsequence

    property p_sw_reset_set;
        s_trig_wr(`IMU_TRIG_RESET) |=> trig[`IMU_TK_RESET];
    endproperty
    a_sw_reset_set: assert property (p_sw_reset_set) else $error("reset trigger not taken");

    property p_flash_set;
        s_trig_wr(`IMU_TRIG_FLASH) |=> trig[`IMU_TK_FLASH];
    endproperty
    a_flash_set: assert property (p_flash_set) else $error("flash trigger not taken");

    property p_launch;
        (state == TK_IDLE) && (trig != 4'h0) |=> (state == TK_RUN) && (task_busy_o != 4'h0);
    endproperty
    a_launch: assert property (p_launch) else $error("pending task not started");

    property p_self_clear;
        (state == TK_RUN) && (timer == 32'h0) && !trig_wr |=> !trig[$past(cur)];
    endproperty
    a_self_clear: assert property (p_self_clear) else $error("trigger bit not cleared");

    property p_reload_hold;
        (state == TK_RELOAD) |=> $stable(res[1]) && $stable(res[6]) && !data_ready_o;
    endproperty
    a_reload_hold: assert property (p_reload_hold) else $error("results changed before reload");

    property p_unused_bits;
        (trig_wr && !(rx_word[7] | rx_word[3] | rx_word[1] | rx_word[0]))
            || (frame_evt && (rx_addr == `IMU_ADDR_TRIG_HI)) |=> (trig & ~$past(trig)) == 4'h0;
    endproperty
    a_unused_bits: assert property (p_unused_bits) else $error("unused trigger bit acted");

    property p_sample_load;
        tick && !hold |=> (res[1] == $past(sens_rate_y_i)) && (res[5] == $past(sens_accel_z_i))
            && (res[6] == {4'h0, $past(sens_temp_i)}) && data_ready_o;
    endproperty
    a_sample_load: assert property (p_sample_load) else $error("sample not loaded");

    property p_whole_word;
        !$stable(res[1]) || !$stable(res[4]) |-> $past(tick && !hold);
    endproperty
    a_whole_word: assert property (p_whole_word) else $error("result changed off sample");

    property p_map_rate_y;
        s_rd(`IMU_ADDR_RATE_Y) |=> tx_word == $past(res[1]);
    endproperty
    a_map_rate_y: assert property (p_map_rate_y) else $error("rate y misread");

    property p_map_accel_z;
        s_rd(`IMU_ADDR_ACCEL_Z) |=> tx_word == $past(res[5]);
    endproperty
    a_map_accel_z: assert property (p_map_accel_z) else $error("accel z misread");

    property p_map_temp;
        s_rd(`IMU_ADDR_TEMP) |=> (tx_word == $past(res[6])) && (tx_word[15:12] == 4'h0);
    endproperty
    a_map_temp: assert property (p_map_temp) else $error("temperature misread");

    property p_burst;
        s_rd(`IMU_ADDR_TRIG) |=> burst_on && (burst_idx == 3'h0) && (tx_word == 16'h0000);
    endproperty
    a_burst: assert property (p_burst) else $error("burst not started");
endmodule // imu_results_top

// ### imu_defs.svh
// Address map, frame fields and timing figures of the inertial result block
`ifndef IMU_DEFS_SVH
`define IMU_DEFS_SVH

// ****************************************************************
// Register byte addresses
// ****************************************************************
`define IMU_ADDR_RATE_X   7'h04
`define IMU_ADDR_RATE_Y   7'h06
`define IMU_ADDR_RATE_Z   7'h08
`define IMU_ADDR_ACCEL_X  7'h0a
`define IMU_ADDR_ACCEL_Y  7'h0c
`define IMU_ADDR_ACCEL_Z  7'h0e
`define IMU_ADDR_TEMP     7'h18
`define IMU_ADDR_TRIG     7'h3e
`define IMU_ADDR_TRIG_HI  7'h3f

// ****************************************************************
// Frame fields and trigger bits
// ****************************************************************
`define IMU_FRM_WR        15
`define IMU_FRM_ADDR      14:8
`define IMU_FRM_DATA      7:0
`define IMU_LAST_BIT      4'hf
`define IMU_TRIG_RESET    7
`define IMU_TRIG_FLASH    3
`define IMU_TRIG_CALIB    1
`define IMU_TRIG_BIAS     0
`define IMU_TK_BIAS       2'd0
`define IMU_TK_CALIB      2'd1
`define IMU_TK_FLASH      2'd2
`define IMU_TK_RESET      2'd3
`define IMU_TEMP_BITS     11:0
`define IMU_TEMP_PAD      4'h0
`define IMU_DIAG_VAL      16'h0000
`define IMU_BURST_LAST    3'd7
`define IMU_IDX_NONE      4'hf

// ****************************************************************
// Timing
// ****************************************************************
`define IMU_CLK_HZ        200000000
`define IMU_SAMPLE_DSPS   8192
`define IMU_FLASH_MS      75
`define IMU_MS_PER_S      1000
// Sample rate is kept in tenths of a sample per second to stay integer
`define IMU_DECI_SCALE    10
`define IMU_TASK_CYC      64
`define IMU_RELOAD_CYC    32

`endif

// ### imu_pkg.sv
// Types shared by the inertial result block
package imu_pkg;
    typedef logic [15:0] imu_word_t;
    typedef enum logic [1:0] {TK_IDLE, TK_RUN, TK_RELOAD} imu_task_e;
endpackage

// ### imu_sync2.sv
// Two-flop level synchroniser into the system clock
`timescale 1ns/1ps
module imu_sync2
    import imu_pkg::*;
(
    input  wire logic       clk_sys_i,
    input  wire logic       rst_b_i,
    input  wire logic [1:0] d_i,
    output logic      [1:0] q_o
);
    logic [1:0] meta;

    always_ff @(posedge clk_sys_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            meta <= 2'h0;
            q_o  <= 2'h0;
        end
        else
        begin
            meta <= d_i;
            q_o  <= meta;
        end
    end
endmodule // imu_sync2

// ### imu_spi_link.sv
// Serial shift logic on the host's serial clock, mode 3, MSB first
`timescale 1ns/1ps
module imu_spi_link
    import imu_pkg::*;
(
    input  wire logic      sclk_i,
    input  wire logic      cs_b_i,
    input  wire logic      rst_b_i,
    input  wire logic      mosi_i,
    input  wire imu_word_t tx_word_i,
    output logic           miso_o,
    output imu_word_t      rx_word_o,
    output logic           rx_tgl_o
);
    // Chip select high restarts the bit count, so a short frame never skews the next
    logic        frame_rst_b;
    logic [3:0]  cnt, next_cnt, txc, next_txc;
    logic [14:0] shift, next_shift, tx_sr, next_tx_sr;
    logic        next_miso, next_tgl, done;
    imu_word_t   next_rx;

    assign frame_rst_b = rst_b_i & ~cs_b_i;

    always_comb
    begin
        done       = (cnt == `IMU_LAST_BIT);
        next_cnt   = cnt + 4'h1;
        next_shift = {shift[13:0], mosi_i};
        next_rx    = done ? {shift, mosi_i} : rx_word_o;
        next_tgl   = rx_tgl_o ^ done;
    end

    always_ff @(posedge sclk_i or negedge frame_rst_b)
    begin
        if (!frame_rst_b)
        begin
            cnt   <= 4'h0;
            shift <= 15'h0;
        end
        else
        begin
            cnt   <= next_cnt;
            shift <= next_shift;
        end
    end

    // Word and toggle survive chip select so the system side never loses a frame
    always_ff @(posedge sclk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            rx_word_o <= 16'h0000;
            rx_tgl_o  <= 1'b0;
        end
        else
        begin
            rx_word_o <= next_rx;
            rx_tgl_o  <= next_tgl;
        end
    end

    // Reply word is quasi-static; it is sampled only at the first falling edge
    always_comb
    begin
        next_txc = txc + 4'h1;
        if (txc == 4'h0)
        begin
            next_miso  = tx_word_i[15];
            next_tx_sr = tx_word_i[14:0];
        end
        else
        begin
            next_miso  = tx_sr[14];
            next_tx_sr = {tx_sr[13:0], 1'b0};
        end
    end

    always_ff @(negedge sclk_i or negedge frame_rst_b)
    begin
        if (!frame_rst_b)
        begin
            txc    <= 4'h0;
            tx_sr  <= 15'h0;
            miso_o <= 1'b0;
        end
        else
        begin
            txc    <= next_txc;
            tx_sr  <= next_tx_sr;
            miso_o <= next_miso;
        end
    end
endmodule // imu_spi_link

// ### imu_host_model.sv
// Host-side serial master model, mode 3, MSB first
`timescale 1ns/1ps
module imu_host_model
(
    output logic      sclk_o,
    output logic      cs_b_o,
    output logic      mosi_o,
    input  wire logic miso_i
);
    // ****************************************
    // Frame driver
    // ****************************************
    initial
    begin
        sclk_o = 1'b1;
        cs_b_o = 1'b1;
        mosi_o = 1'b0;
    end

    // Whole 16-bit frame per call; keep holds select low for a burst
    task automatic frame(input logic [15:0] w, input logic keep, output logic [15:0] r);
        cs_b_o = 1'b0;
        for (int i = 15; i >= 0; i--)
        begin
            #3 sclk_o = 1'b0;
            mosi_o = w[i];
            #3 sclk_o = 1'b1;
            r[i] = miso_i;
        end
        // Released line flips so a stale bit never looks valid
        #3 mosi_o = ~mosi_o;
        cs_b_o = ~keep;
        // Idle gap gives the reply word time to cross domains
        #60;
    endtask
endmodule // imu_host_model

// ### tb_top.sv
// Self-checking bench for the inertial result block
`timescale 1ns/1ps
module tb_top
    import imu_pkg::*;
;
    // ****************************************
    // Signals and instances
    // ****************************************
    logic        clk_sys_i;
    logic        rst_b_i;
    logic        sclk;
    logic        cs_b;
    logic        mosi;
    logic        miso;
    logic        data_ready;
    logic        ctrl_reload;
    logic [3:0]  task_busy;
    imu_word_t   sens [6];
    logic [11:0] temp;
    imu_word_t   rep;
    int          n_fail;
    int          compares;
    imu_word_t   vals [2][6] = '{'{16'h61a8, 16'h9e58, 16'hffff, 16'h4e20, 16'hb1e0, 16'h0002},
                                 '{16'h0001, 16'hfffe, 16'h0000, 16'h0002, 16'hffff, 16'h7fff}};
    logic [11:0] tvals [2] = '{12'hc3e, 12'h3ea};
    logic [7:0]  tbit [4] = '{8'h01, 8'h02, 8'h08, 8'h80};

    // Reset task runs its full default length; the loop bound leaves room for it
    imu_results_top #(.SAMPLE_CYC(30), .FLASH_CYC(40), .CALIB_CYC(40), .BIAS_CYC(40),
                      .RELOAD_CYC(4)) dut_u (
        .clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .sclk_i(sclk), .cs_b_i(cs_b), .mosi_i(mosi),
        .sens_rate_x_i(sens[0]), .sens_rate_y_i(sens[1]), .sens_rate_z_i(sens[2]),
        .sens_accel_x_i(sens[3]), .sens_accel_y_i(sens[4]), .sens_accel_z_i(sens[5]),
        .sens_temp_i(temp), .miso_o(miso), .data_ready_o(data_ready), .task_busy_o(task_busy),
        .ctrl_reload_o(ctrl_reload));

    imu_host_model host_u (.sclk_o(sclk), .cs_b_o(cs_b), .mosi_o(mosi), .miso_i(miso));

    initial
    begin
        clk_sys_i = 1'b0;
        forever #2.5 clk_sys_i = ~clk_sys_i;
    end

    // ****************************************
    // Tasks
    // ****************************************
    task automatic chk(input string nm, input imu_word_t exp, input imu_word_t got);
        compares++;
        if (got !== exp)
        begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic end_of_test;
        $display("Comparisons %0d, mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic tick(input logic ok);
        @(posedge clk_sys_i);
        #1;
        if (!ok)
        begin
            chk("wait_bound", 16'h0001, 16'h0000);
            end_of_test();
        end
    endtask

    // Two pulses guarantee a tick that saw the new inputs
    task automatic load(input int s);
        int k;
        int seen;
        k = 0;
        seen = 0;
        @(posedge clk_sys_i);
        for (int a = 0; a < 6; a++)
            sens[a] <= vals[s][a];
        temp <= tvals[s];
        while (seen < 2)
        begin
            tick(k < 200);
            k++;
            if (data_ready === 1'b1)
                seen++;
        end
    endtask

    task automatic read_all;
        logic [6:0] ad [9] = '{7'h04, 7'h06, 7'h08, 7'h0a, 7'h0c, 7'h0e, 7'h18, 7'h07, 7'h20};
        imu_word_t  ex [9] = '{sens[0], sens[1], sens[2], sens[3], sens[4], sens[5], {4'h0, temp}, sens[1],
                               16'h0000};
        host_u.frame({1'b0, ad[0], 8'h00}, 1'b0, rep);
        for (int j = 1; j <= 9; j++)
        begin
            host_u.frame((j < 9) ? {1'b0, ad[j], 8'h00} : 16'h0000, 1'b0, rep);
            chk("read_reply", ex[j - 1], rep);
        end
    endtask

    task automatic burst;
        imu_word_t bex [8] = '{16'h0000, sens[0], sens[1], sens[2], sens[3], sens[4], sens[5], {4'h0, temp}};
        host_u.frame(16'h3e00, 1'b1, rep);
        for (int j = 0; j < 8; j++)
        begin
            host_u.frame(16'h0000, j < 7, rep);
            chk("burst_word", bex[j], rep);
        end
    endtask

    task automatic trigger(input int t);
        int   k;
        int   gated;
        logic prev;
        logic seen_rl;
        k = 0;
        gated = 0;
        prev = 1'b0;
        seen_rl = 1'b0;
        host_u.frame({8'hbe, tbit[t]}, 1'b0, rep);
        chk("task_busy", 16'(1 << t), 16'(task_busy));
        while (task_busy !== 4'h0 || ctrl_reload !== 1'b0)
        begin
            tick(k < 400);
            k++;
            if (prev && data_ready === 1'b1)
                gated++;
            prev = task_busy[3] | task_busy[2] | ctrl_reload;
            if (ctrl_reload === 1'b1)
                seen_rl = 1'b1;
        end
        chk("reload_seen", 16'(t >= 2), 16'(seen_rl));
        chk("gated_ready", 16'h0000, 16'(gated));
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial
    begin
        n_fail = 0;
        compares = 0;
        rst_b_i = 1'b0;
        temp = 12'h000;
        for (int a = 0; a < 6; a++)
            sens[a] = 16'h0000;
        repeat (10) @(posedge clk_sys_i);
        rst_b_i <= 1'b1;
        repeat (3) @(posedge clk_sys_i);
        #1;
        chk("busy_after_reset", 16'h0000, 16'(task_busy));
        chk("reload_after_reset", 16'h0000, 16'(ctrl_reload));
        for (int s = 0; s < 2; s++)
        begin
            load(s);
            read_all();
        end
        burst();
        for (int t = 0; t < 4; t++)
            trigger(t);
        // Unused trigger bits, the high byte and another address must start nothing
        host_u.frame(16'hbe74, 1'b0, rep);
        chk("unused_bits", 16'h0000, 16'(task_busy));
        host_u.frame(16'hbf80, 1'b0, rep);
        chk("high_byte", 16'h0000, 16'(task_busy));
        host_u.frame(16'hbc01, 1'b0, rep);
        chk("other_addr", 16'h0000, 16'(task_busy));
        end_of_test();
    end
endmodule // tb_top
